// *** logic/spi_status_state_observer.sv ***
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1: Disabling the port returns every status bit to its reset value.
// R2: Bit 7 set when transmit holding empty, cleared by transmit data write.
// R3: Bit 7 reads zero while holding is full or port disabled.
// R4: Underrun, collision, abort, overrun readable; writing one clears them.
// R5: Bit 6 sets on transmit underrun and holds until cleared.
// R6: Bit 5 sets on multi-master collision (mode fault).
// R7: Slave: bit 4 sets if select deasserts before character completes; the code does so for SPI slaves only, not in I2S mode.
// R8: Slave with baud control set: bit 4 sets on clock monitor timeout.
// R9: Bit 3 sets on receive overrun, holds until a one is written.
// R10: Bit 2 set when receive data held, cleared by reading receive data.
// R11: Bit 1 high while a transfer is in progress.
// R12: Bit 0 is select pin XOR polarity; zero means asserted; resets one.
// R13: State bit 7 shows the serial clock pin level.
// R14: State bit 6 shows serial input: master-input (miso) as master, else slave-input (mosi).
// R15: State bits 5:0 show the engine state code, read-only, reset zero.
// R16: Idle 000000, slave wait 000001, I2S slave delays 000010 and 000011.
// R17: SPI master delay 010000, I2S master delays 110001 and 110010.
// R18: Bit states are 10, bit index, phase; receive even, transmit odd.
// R19: Select polarity zero means active low, one means active high.
// R20: Writing zero to clearable flags or writing read-only bits changes nothing.
module spi_status_state_observer #(
  parameter int unsigned SCK_TIMEOUT = spi_observer_pkg::SCK_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  logic        hclk,
  input  logic        hresetn,
  // AHB-Lite slave
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic        hready,
  input  logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  // Serial pins
  input  logic        sck_pin,
  input  logic        select_pin,
  input  logic        mosi_pin,
  input  logic        miso_pin,
  // Transmit holding toward the shifter
  output logic [7:0]  tx_holding
);
  import spi_observer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]       pin_s1;
  logic [3:0]       pin_s2;
  logic [3:0]       pin_s3;
  logic [3:0]       pin_agree;
  pins_type         pin;
  pins_type         pin_prev;
  pins_type         next_pin;
  logic             sck_rise;
  logic             sck_fall;
  logic             sel_asserted;
  logic             sel_change;
  logic             serial_in;
  logic             bus_take;
  logic             wr_pend;
  logic [29:0]      wr_index;
  logic             wr_status;
  logic             wr_ctrl;
  logic             wr_tx;
  logic             rd_rx;
  logic [7:0]       read_byte;
  status_type       status_clear;
  control_type      ctrl;
  status_type       status;
  status_type       next_status;
  logic             holding_full;
  logic             next_holding_full;
  logic [7:0]       shift_in;
  logic [7:0]       rx_data;
  engine_state_type state;
  engine_state_type next_state;
  logic [2:0]       bit_index;
  logic [2:0]       next_bit;
  logic [2:0]       top_bit;
  logic             in_bits;
  logic             master;
  logic             en;
  logic             char_start;
  logic             char_done;
  logic             abort_evt;
  logic [15:0]      idle_count;
  logic             timeout_hit;
  logic             underrun_evt;
  logic             collision_evt;
  logic             overrun_evt;
  engine_view_type  view;

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic sticky_next(
    input logic flag,
    input logic evt,
    input logic clr,
    input logic enable
  );
    // Set beats a simultaneous clear
    sticky_next = enable & (evt | (flag & ~clr));
  endfunction

  function automatic logic [5:0] state_code(
    input engine_state_type st,
    input logic [2:0]       b
  );
    case (st)
      ST_IDLE:  state_code = CODE_IDLE;
      ST_WAIT:  state_code = CODE_SLAVE_WAIT;
      ST_SDLY0: state_code = CODE_I2S_SLAVE_0;
      ST_SDLY1: state_code = CODE_I2S_SLAVE_1;
      ST_MDLY:  state_code = CODE_SPI_MASTER;
      ST_IDLY0: state_code = CODE_I2S_MASTER_0;
      ST_IDLY1: state_code = CODE_I2S_MASTER_1;
      ST_RX:    state_code = {CODE_BIT_PREFIX, b, 1'b0};
      ST_TX:    state_code = {CODE_BIT_PREFIX, b, 1'b1};
      default:  state_code = CODE_IDLE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree
  assign pin_agree = ~(pin_s2 ^ pin_s3);
  assign next_pin  = pins_type'((pin_s2 & pin_agree) | (pin & ~pin_agree));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1   <= PIN_RESET;
      pin_s2   <= PIN_RESET;
      pin_s3   <= PIN_RESET;
      pin      <= pins_type'(PIN_RESET);
      pin_prev <= pins_type'(PIN_RESET);
    end else begin
      pin_s1   <= {sck_pin, select_pin, mosi_pin, miso_pin};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin      <= next_pin;
      pin_prev <= pin;
    end
  end

  assign sck_rise     = pin.sck & ~pin_prev.sck;
  assign sck_fall     = ~pin.sck & pin_prev.sck;
  assign sel_asserted = ~(pin.select ^ ctrl.select_polarity); // R19
  assign sel_change   = pin.select ^ pin_prev.select;
  assign serial_in    = ctrl.master_enable ? pin.miso : pin.mosi; // R14

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode; writes land in the data phase, reads answer with no wait
  assign bus_take     = hsel & htrans[1] & hready;
  assign wr_status    = wr_pend & (wr_index == STATUS_INDEX);
  assign wr_ctrl      = wr_pend & (wr_index == CONTROL_INDEX);
  assign wr_tx        = wr_pend & (wr_index == TX_DATA_INDEX) & en;
  assign rd_rx        = bus_take & ~hwrite & (haddr[31:2] == RX_DATA_INDEX);
  assign status_clear = status_type'(hwdata[7:0] & {8{wr_status}}); // R4 R20

  // Unmapped addresses and the write-only holding read as zero
  assign read_byte =
    (haddr[31:2] == STATUS_INDEX)  ? status :
    (haddr[31:2] == STATE_INDEX)   ? view :
    (haddr[31:2] == CONTROL_INDEX) ? ctrl :
    (haddr[31:2] == RX_DATA_INDEX) ? rx_data : DATA_RESET;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_index  <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= bus_take & hwrite;
      wr_index  <= haddr[31:2];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (bus_take & ~hwrite) begin
        hrdata <= {24'h000000, read_byte};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl       <= control_type'(CONTROL_RESET);
      tx_holding <= DATA_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= control_type'(hwdata[7:0]);
      end
      if (wr_tx) begin
        tx_holding <= hwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine state machine
  assign en      = ctrl.port_enable;
  assign master  = ctrl.master_enable;
  assign in_bits = (state == ST_RX) | (state == ST_TX);
  assign top_bit = (ctrl.character_length == 3'h0) ? 3'h7 : 3'(ctrl.character_length - 3'h1);
  assign timeout_hit = ctrl.baud_generator_control & (idle_count == 16'(SCK_TIMEOUT - 1));

  always_comb begin
    next_state = state;
    next_bit   = bit_index;
    char_start = 1'b0;
    char_done  = 1'b0;
    abort_evt  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (master) begin
          if (holding_full) begin
            next_state = ctrl.i2s_mode ? ST_IDLY0 : ST_MDLY;
          end
        end else if (ctrl.i2s_mode) begin
          if (sel_change) begin
            next_state = ST_SDLY0;
          end
        end else if (sel_asserted) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!sel_asserted) begin
          next_state = ST_IDLE;
        end else begin
          char_start = 1'b1;
        end
      end
      ST_SDLY0, ST_IDLY0: begin
        if (sck_fall) begin
          next_state = (state == ST_SDLY0) ? ST_SDLY1 : ST_IDLY1;
        end
      end
      ST_SDLY1, ST_IDLY1, ST_MDLY: begin
        char_start = sck_fall | (state == ST_MDLY);
      end
      ST_RX: begin
        if (sck_rise) begin
          next_state = ST_TX;
        end
      end
      ST_TX: begin
        if (sck_fall) begin
          if (bit_index == 3'h0) begin
            char_done = 1'b1;
            if (master) begin
              char_start = holding_full;
              next_state = ST_IDLE;
            end else begin
              next_state = ctrl.i2s_mode ? ST_IDLE : ST_WAIT;
            end
          end else begin
            next_state = ST_RX;
            next_bit   = bit_index - 3'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (char_start) begin
      next_state = ST_RX;
      next_bit   = top_bit;
    end
    // I2S select toggles every frame, so only SPI slaves abort on it
    if (!master && in_bits && !char_done && ((!sel_asserted && !ctrl.i2s_mode) || timeout_hit)) begin // R7 R8
      abort_evt  = 1'b1;
      next_state = ST_IDLE;
    end
    if (!en) begin
      next_state = ST_IDLE; // R1
      next_bit   = 3'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      bit_index <= 3'h0;
    end else begin
      state     <= next_state;
      bit_index <= next_bit;
    end
  end

  // Monitor counts quiet cycles between clock edges during a character
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_count <= 16'h0000;
    end else if (!in_bits || sck_rise || sck_fall) begin
      idle_count <= 16'h0000;
    end else begin
      idle_count <= idle_count + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_in <= DATA_RESET;
      rx_data  <= DATA_RESET;
    end else begin
      if (state == ST_RX && sck_rise) begin
        shift_in <= {shift_in[6:0], serial_in};
      end
      if (char_done) begin
        rx_data <= shift_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags
  // A slave starting with nothing queued shifts stale data
  assign underrun_evt  = char_start & ~master & ~holding_full;
  // Select asserted by someone else while we sit idle as master
  assign collision_evt = master & sel_asserted & (state == ST_IDLE);
  assign overrun_evt   = char_done & status.rx_holding_full_flag & ~rd_rx;

  assign next_holding_full = en & (wr_tx | (holding_full & ~char_start));

  assign next_status = status_type'({
    en & ~next_holding_full, // R2 R3
    sticky_next(status.tx_underrun_flag, underrun_evt,
                status_clear.tx_underrun_flag, en), // R5
    sticky_next(status.collision_flag, collision_evt,
                status_clear.collision_flag, en), // R6
    sticky_next(status.slave_abort_flag, abort_evt,
                status_clear.slave_abort_flag, en), // R7 R8
    sticky_next(status.rx_overrun_flag, overrun_evt,
                status_clear.rx_overrun_flag, en), // R9
    sticky_next(status.rx_holding_full_flag, char_done, rd_rx, en), // R10
    en & (next_state != ST_IDLE) & (next_state != ST_WAIT), // R11
    en ? (pin.select ^ ctrl.select_polarity) : 1'b1 // R12 R1
  });

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status       <= status_type'(STATUS_RESET);
      holding_full <= 1'b0;
    end else begin
      status       <= next_status; // R1
      holding_full <= next_holding_full;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State view; the pins come through the synchroniser, then one more register every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      view <= engine_view_type'(STATE_RESET);
    end else begin
      view <= engine_view_type'({pin.sck, serial_in, // R13 R14
                                 state_code(next_state, next_bit)}); // R15 R16 R17 R18
    end
  end

endmodule

// *** logic/spi_observer_pkg.sv ***
package spi_observer_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned SCK_TIMEOUT_NS     = 20000;
  localparam int unsigned SCK_TIMEOUT_CYCLES =
    (SCK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [29:0] STATUS_INDEX  = 30'h00FFE264;
  localparam logic [29:0] STATE_INDEX   = 30'h00FFE265;
  localparam logic [29:0] CONTROL_INDEX = 30'h00FFE270;
  localparam logic [29:0] TX_DATA_INDEX = 30'h00FFE271;
  localparam logic [29:0] RX_DATA_INDEX = 30'h00FFE272;

  // Reset values
  localparam logic [7:0] STATUS_RESET  = 8'h01;
  localparam logic [7:0] STATE_RESET   = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [3:0] PIN_RESET     = 4'h4;

  // Engine state codes
  localparam logic [5:0] CODE_IDLE        = 6'h00;
  localparam logic [5:0] CODE_SLAVE_WAIT  = 6'h01;
  localparam logic [5:0] CODE_I2S_SLAVE_0 = 6'h02;
  localparam logic [5:0] CODE_I2S_SLAVE_1 = 6'h03;
  localparam logic [5:0] CODE_SPI_MASTER  = 6'h10;
  localparam logic [5:0] CODE_I2S_MASTER_0 = 6'h31;
  localparam logic [5:0] CODE_I2S_MASTER_1 = 6'h32;
  localparam logic [1:0] CODE_BIT_PREFIX  = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_SDLY0, ST_SDLY1, ST_MDLY,
    ST_IDLY0, ST_IDLY1, ST_RX, ST_TX
  } engine_state_type;

  // Field layouts, most significant bit first
  typedef struct packed {
    logic [2:0] character_length;
    logic       i2s_mode;
    logic       baud_generator_control;
    logic       select_polarity;
    logic       master_enable;
    logic       port_enable;
  } control_type;

  typedef struct packed {
    logic tx_holding_empty_flag;
    logic tx_underrun_flag;
    logic collision_flag;
    logic slave_abort_flag;
    logic rx_overrun_flag;
    logic rx_holding_full_flag;
    logic transfer_active_flag;
    logic select_level_flag;
  } status_type;

  typedef struct packed {
    logic       serial_clock_pin_sample;
    logic       serial_input_pin_sample;
    logic [5:0] engine_state_code;
  } engine_view_type;

  typedef struct packed {
    logic sck;
    logic select;
    logic mosi;
    logic miso;
  } pins_type;

endpackage

// *** tb/spi_observer_assertions.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module spi_observer_assertions
  import spi_observer_pkg::*;
#(
  parameter int unsigned SCK_TIMEOUT = 20
) (
  // Clock and reset
  input logic        hclk,
  input logic        hresetn,
  // Bus
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  // Pins
  input logic        sck_pin,
  input logic        select_pin,
  input logic        mosi_pin,
  input logic        miso_pin,
  input logic [7:0]  tx_holding
);
  logic        a_rd;
  logic        a_wr;
  logic [29:0] a_ix;
  control_type ctl;
  logic [3:0]  ctl_age;
  logic [3:0]  pin_age;
  logic [3:0]  pins_q;
  wire logic [3:0] pins    = {sck_pin, select_pin, mosi_pin, miso_pin};
  wire logic       take    = hsel & htrans[1] & hready;
  wire logic       rd_stat = a_rd && a_ix == STATUS_INDEX;
  wire logic       rd_st   = a_rd && a_ix == STATE_INDEX;
  wire logic       wr_tx   = a_wr && a_ix == TX_DATA_INDEX;
  // Pin bits lag the synchroniser, so only settled reads are judged
  wire logic       quiet   = pin_age > 4'hB && ctl_age > 4'h5;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_rd <= 1'h0;
      a_wr <= 1'h0;
      a_ix <= '0;
    end else begin
      a_rd <= take & ~hwrite;
      a_wr <= take & hwrite;
      a_ix <= haddr[31:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl     <= '0;
      ctl_age <= '0;
    end else if (a_wr && a_ix == CONTROL_INDEX) begin
      ctl     <= hwdata[7:0];
      ctl_age <= '0;
    end else if (ctl_age != 4'hF) begin
      ctl_age <= ctl_age + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q  <= '0;
      pin_age <= '0;
    end else begin
      pins_q  <= pins;
      pin_age <= (pins != pins_q) ? 4'h0 : (pin_age == 4'hF ? pin_age : pin_age + 4'h1);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  chk_off_status: assert property (rd_stat && !ctl.port_enable && ctl_age > 4'h5 |-> hrdata[7:0] == 8'h01)
    else $error("status not at reset value while disabled");
  chk_off_state: assert property (rd_st && !ctl.port_enable && ctl_age > 4'h5 |-> hrdata[5:0] == 6'h00)
    else $error("state code not zero while disabled");
  chk_sel_level: assert property (rd_stat && ctl.port_enable && quiet |-> hrdata[0] == (select_pin ^ ctl.select_polarity))
    else $error("select level bit wrong");
  chk_sck_view: assert property (rd_st && ctl.port_enable && quiet |-> hrdata[7] == sck_pin)
    else $error("clock pin bit wrong");
  chk_data_in: assert property (rd_st && ctl.port_enable && quiet |-> hrdata[6] == (ctl.master_enable ? miso_pin : mosi_pin))
    else $error("data input bit wrong");
  chk_code_legal: assert property (rd_st |-> hrdata[5:4] == 2'h2 || hrdata[5:0] inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h10, 6'h31, 6'h32})
    else $error("state code outside the encoding");
  chk_tx_load: assert property (wr_tx && ctl.port_enable && ctl_age > 4'h2 |=> tx_holding == $past(hwdata[7:0]))
    else $error("transmit holding not loaded");
  chk_tx_refuse: assert property (wr_tx && !ctl.port_enable |=> $stable(tx_holding))
    else $error("transmit holding loaded while disabled");

  cov_abort: cover property (rd_stat && hrdata[4]);
  cov_collide: cover property (rd_stat && hrdata[5]);
  cov_overrun: cover property (rd_stat && hrdata[3]);
endmodule

bind spi_status_state_observer spi_observer_assertions #(.SCK_TIMEOUT(SCK_TIMEOUT)) chk_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
  .hreadyout, .hresp, .sck_pin, .select_pin, .mosi_pin, .miso_pin, .tx_holding
);

// *** tb/spi_far_end.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// Far serial master, mode 0; clock stands still outside frames
module spi_far_end #(
  parameter realtime HALF = 62.5
) (
  // Lines toward the port
  output logic sck,
  output logic sel,
  output logic mosi
);
  initial begin
    sck  = 1'h0;
    sel  = 1'h1;
    mosi = 1'h0;
  end

  task automatic hold(input logic s, input logic d);
    sel  <= s;
    mosi <= d;
  endtask

  // Shifts n bits MSB first, keeps select extra_ns, then releases
  task automatic frame(input logic [7:0] d, input int n, input int extra_ns);
    sel <= 1'h0;
    #(HALF);
    for (int i = 7; i > 7 - n; i--) begin
      mosi <= d[i];
      #(HALF);
      sck <= 1'h1;
      #(HALF);
      sck <= 1'h0;
    end
    // Released data line must not keep the last bit
    mosi <= ~mosi;
    #(extra_ns);
    sel <= 1'h1;
    #(HALF);
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module tb;
  import spi_observer_pkg::*;
  localparam logic [31:0] A_STAT  = 32'h03FF8990;
  localparam logic [31:0] A_STATE = 32'h03FF8994;
  localparam logic [31:0] A_NONE  = 32'h03FF8998;
  localparam logic [31:0] A_CTL   = 32'h03FF89C0;
  localparam logic [31:0] A_TX    = 32'h03FF89C4;
  localparam logic [31:0] A_RX    = 32'h03FF89C8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        sck_pin, select_pin, mosi_pin, miso_pin;
  logic [7:0]  tx_holding;
  int          err_total, num_checks;
  wire logic   hready = hreadyout;

  // Short clock monitor timeout keeps the run brief
  spi_status_state_observer #(.SCK_TIMEOUT(20)) spi_status_state_observer_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .sck_pin, .select_pin, .mosi_pin, .miso_pin, .tx_holding
  );
  spi_far_end spi_far_end_i (.sck(sck_pin), .sel(select_pin), .mosi(mosi_pin));

  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] x);
    num_checks++;
    if (x !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, x);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] rd);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'h1, a, d, x);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] x;
    xfer(1'h0, a, 8'h00, x);
    cmp(nm, {24'h0, e}, x & {24'hFFFFFF, m});
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [7:0] e);
    rchk(nm, a, 8'hFF, e);
  endtask

  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask

  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, miso_pin} = '0;
    hsize = 3'h2;
    err_total = 0;
    num_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rc("status", A_STAT, 8'h01);
    rc("state", A_STATE, 8'h00);
    rc("unmapped", A_NONE, 8'h00);
    $display("test reset done");
    wr(A_CTL, 8'h01);
    settle();
    rc("status", A_STAT, 8'h81);
    wr(A_STAT, 8'hFF);
    wr(A_STATE, 8'hFF);
    rc("status", A_STAT, 8'h81);
    rc("state", A_STATE, 8'h00);
    wr(A_TX, 8'hA5);
    rc("status", A_STAT, 8'h01);
    cmp("tx_holding", 32'hA5, {24'h0, tx_holding});
    spi_far_end_i.frame(8'h96, 8, 0);
    settle();
    rc("status", A_STAT, 8'h85);
    rc("rx data", A_RX, 8'h96);
    repeat (2) @(posedge hclk);
    rc("status", A_STAT, 8'h81);
    $display("test receive done");
    // Empty holding then full receiver: underrun and overrun together
    spi_far_end_i.frame(8'h5A, 8, 0);
    spi_far_end_i.frame(8'h33, 8, 0);
    settle();
    rc("status", A_STAT, 8'hCD);
    wr(A_STAT, 8'h00);
    rc("status", A_STAT, 8'hCD);
    wr(A_STAT, 8'h48);
    rc("status", A_STAT, 8'h85);
    rc("rx data", A_RX, 8'h33);
    $display("test errors done");
    wr(A_TX, 8'h11);
    fork
      spi_far_end_i.frame(8'h3C, 2, 600);
    join_none
    repeat (50) @(posedge hclk);
    rc("state", A_STATE, 8'h6A);
    rc("status", A_STAT, 8'h82);
    wait fork;
    settle();
    rc("status", A_STAT, 8'h91);
    wr(A_STAT, 8'h10);
    $display("test abort done");
    wr(A_CTL, 8'h09);
    wr(A_TX, 8'h22);
    fork
      spi_far_end_i.frame(8'hC3, 2, 600);
    join_none
    repeat (70) @(posedge hclk);
    rchk("abort flag", A_STAT, 8'h10, 8'h10);
    wait fork;
    settle();
    // Restarts after the timeout ran with nothing queued, so underrun is set too
    wr(A_STAT, 8'h50);
    rc("status", A_STAT, 8'h81);
    $display("test timeout done");
    wr(A_CTL, 8'h03);
    spi_far_end_i.hold(1'h0, 1'h0);
    miso_pin <= 1'h1;
    settle();
    rc("status", A_STAT, 8'hA0);
    rc("state", A_STATE, 8'h40);
    wr(A_CTL, 8'h00);
    settle();
    rc("status", A_STAT, 8'h01);
    rchk("state code", A_STATE, 8'h3F, 8'h00);
    $display("test collision done");
    wr(A_CTL, 8'h07);
    settle();
    rc("status", A_STAT, 8'h81);
    spi_far_end_i.hold(1'h1, 1'h0);
    settle();
    rc("status", A_STAT, 8'hA0);
    wr(A_CTL, 8'h00);
    $display("test polarity done");
    // Master start with select idle: holding moves into bit 7 receive
    wr(A_CTL, 8'h03);
    wr(A_TX, 8'h44);
    settle();
    rc("state", A_STATE, 8'h6E);
    rc("status", A_STAT, 8'h83);
    wr(A_CTL, 8'h00);
    wr(A_TX, 8'hEE);
    cmp("tx_holding", 32'h44, {24'h0, tx_holding});
    $display("test master done");
    end_sim();
  end
endmodule
